// >>> rtl/sfds_pkg.sv
// shared constants and types for the spi frame decoder and its host end
package sfds_pkg;

    // frame layout, msb first on the wire
    localparam int FRAME_BITS = 16;
    localparam int BIT_RW     = 15;
    localparam int BIT_TGT    = 14;
    localparam int ADDR_MSB   = 13;
    localparam int ADDR_LSB   = 9;
    localparam int BIT_PAR    = 8;
    localparam int DATA_MSB   = 7;
    localparam int ADDR_W     = 5;
    localparam int DATA_W     = 8;

    // rw bit and target select encodings
    localparam logic RW_READ      = 1'b0;
    localparam logic RW_WRITE     = 1'b1;
    localparam logic TGT_MAIN     = 1'b0;
    localparam logic TGT_FAILSAFE = 1'b1;

    // bit counts inside a frame
    localparam logic [4:0] CNT_HDR   = 5'h06;
    localparam logic [4:0] CNT_LOW   = 5'h08;
    localparam logic [4:0] CNT_FRAME = 5'h10;
    localparam logic [4:0] CNT_MAX   = 5'h1f;

    // summary flag positions inside the high miso byte
    localparam int FLAG_SPI   = 7;
    localparam int FLAG_WAKE  = 6;
    localparam int FLAG_CAN   = 5;
    localparam int FLAG_LIN   = 4;
    localparam int FLAG_IO    = 3;
    localparam int FLAG_PRE   = 2;
    localparam int FLAG_CORE  = 1;
    localparam int FLAG_OTHER = 0;
    localparam logic [7:0] SUMMARY_RST = 8'h00;

    // number of source flags behind each summary flag
    localparam int N_SPI_SRC   = 8;
    localparam int N_WAKE_SRC  = 7;
    localparam int N_CAN_SRC   = 9;
    localparam int N_LIN_SRC   = 4;
    localparam int N_IO_SRC    = 6;
    localparam int N_PRE_SRC   = 9;
    localparam int N_CORE_SRC  = 5;
    localparam int N_OTHER_SRC = 15;

    // host register map and fields
    localparam int REG_AW = 4;
    localparam int REG_DW = 16;
    localparam logic [3:0] REG_CMD    = 4'h0;
    localparam logic [3:0] REG_RX     = 4'h4;
    localparam logic [3:0] REG_STATUS = 4'h8;
    localparam logic [3:0] REG_MASK   = 4'hc;
    localparam int EVT_W       = 2;
    localparam int EVT_DONE    = 0;
    localparam int EVT_REFUSED = 1;
    localparam int ST_BUSY     = 8;
    localparam logic [1:0] EVT_RST = 2'h0;

    // timing
    localparam int REF_CLK_PERIOD_NS = 100;
    localparam int SCLK_PERIOD_NS    = 800;
    localparam int SCLK_HALF_CYC =
        (SCLK_PERIOD_NS / 2 + REF_CLK_PERIOD_NS - 1) / REF_CLK_PERIOD_NS;

    typedef enum logic {
        SFDS_DEV_IDLE  = 1'b0,
        SFDS_DEV_SHIFT = 1'b1
    } sfds_dev_st_t;

    typedef enum logic [2:0] {
        SFDS_H_IDLE  = 3'h0,
        SFDS_H_LEAD  = 3'h1,
        SFDS_H_HIGH  = 3'h3,
        SFDS_H_LOW   = 3'h2,
        SFDS_H_TRAIL = 3'h6,
        SFDS_H_GAP   = 3'h4
    } sfds_host_st_t;

    // parity value a frame must carry: 0 for odd ones, 1 for even
    function automatic logic sfds_par_bit(input logic [15:0] f);
        return ~^{f[15:9], f[7:0]};
    endfunction : sfds_par_bit

endpackage : sfds_pkg

// >>> rtl/sfds_link_if.sv
// spi link between the frame decoder and its host
`timescale 1ns/1ps
interface sfds_link_if;
    logic sclk;   // serial clock, idle low
    logic cs_n;   // frame select, active low
    logic mosi;   // host to device data
    logic miso;   // device to host data

    modport dev  (input sclk, input cs_n, input mosi, output miso);
    modport host (output sclk, output cs_n, output mosi, input miso);
endinterface : sfds_link_if

// >>> rtl/sfds_host.sv
// host end: register-driven spi master for the frame decoder
`timescale 1ns/1ps
module sfds_host #(
    parameter int HALF_CYC = sfds_pkg::SCLK_HALF_CYC  // cycles per half sclk
) (
    input  wire logic                       ref_clk, // system clock
    input  wire logic                       rstn,    // async reset, low
    sfds_link_if.host                       link,    // spi pins
    input  wire logic [sfds_pkg::REG_AW-1:0] addr,   // register address
    input  wire logic [sfds_pkg::REG_DW-1:0] wdata,  // write data
    input  wire logic                       wr,      // write strobe
    input  wire logic                       rd,      // read strobe
    output logic      [sfds_pkg::REG_DW-1:0] rdata,  // read data, next cycle
    output logic                            irq      // level interrupt
);

    typedef struct packed {
        sfds_pkg::sfds_host_st_t st;
        logic [7:0]  div;
        logic [4:0]  bits;
        logic [15:0] cmd;
        logic [15:0] tx;
        logic [15:0] rx;
        logic [2:0]  miso_s;
        logic        miso_f;
        logic        sclk;
        logic        cs_n;
        logic        mosi;
        logic [1:0]  status;
        logic [1:0]  mask;
        logic [15:0] rdata;
        logic        irq;
    } sfds_host_state_t;

    sfds_host_state_t r;
    sfds_host_state_t n;
    logic             tick;
    logic [15:0]      frame;
    logic [1:0]       evt;

    assign link.sclk = r.sclk;
    assign link.cs_n = r.cs_n;
    assign link.mosi = r.mosi;
    assign rdata     = r.rdata;
    assign irq       = r.irq;

    // next state: divider, frame sequencer, registers
    always_comb
    begin
        n     = r;
        evt   = 2'h0;
        frame = wdata;
        tick  = (r.div == 8'(HALF_CYC - 1));
        // read frames carry zero data and zero parity
        if (wdata[sfds_pkg::BIT_RW] == sfds_pkg::RW_READ)
        begin
            frame[sfds_pkg::DATA_MSB:0] = 8'h00;
            frame[sfds_pkg::BIT_PAR]    = 1'b0;
        end
        else
        begin
            frame[sfds_pkg::BIT_PAR] = sfds_pkg::sfds_par_bit(wdata);
        end
        n.miso_s = {r.miso_s[1:0], link.miso};
        if (r.miso_s[1] == r.miso_s[2])
        begin
            n.miso_f = r.miso_s[2];
        end
        n.div = (r.st == sfds_pkg::SFDS_H_IDLE || tick) ? 8'h00
                                                        : r.div + 8'h01;
        unique case (r.st)
            sfds_pkg::SFDS_H_IDLE:
                if (wr && addr == sfds_pkg::REG_CMD)
                begin
                    // frame fields follow the wire layout
                    n.cmd  = frame;
                    n.tx   = frame;
                    n.cs_n = 1'b0;
                    n.mosi = frame[15];
                    n.bits = 5'h00;
                    n.st   = sfds_pkg::SFDS_H_LEAD;
                end
            sfds_pkg::SFDS_H_LEAD, sfds_pkg::SFDS_H_LOW:
                if (tick)
                begin
                    n.sclk = 1'b1;
                    n.st   = sfds_pkg::SFDS_H_HIGH;
                end
            sfds_pkg::SFDS_H_HIGH:
                if (tick)
                begin
                    // sample at the falling edge, taking this cycle's
                    // filtered miso: the two pin filters eat a full bit
                    n.sclk = 1'b0;
                    n.rx   = {r.rx[14:0], n.miso_f};
                    n.bits = r.bits + 5'h01;
                    n.tx   = {r.tx[14:0], 1'b0};
                    n.mosi = r.tx[14];
                    n.st   = (r.bits == sfds_pkg::CNT_FRAME - 5'h01)
                             ? sfds_pkg::SFDS_H_TRAIL : sfds_pkg::SFDS_H_LOW;
                end
            sfds_pkg::SFDS_H_TRAIL:
                if (tick)
                begin
                    n.cs_n = 1'b1;
                    n.mosi = 1'b0;
                    evt[sfds_pkg::EVT_DONE] = 1'b1;
                    n.st   = sfds_pkg::SFDS_H_GAP;
                end
            sfds_pkg::SFDS_H_GAP:
                if (tick)
                begin
                    n.st = sfds_pkg::SFDS_H_IDLE;
                end
            default:
                n.st = sfds_pkg::SFDS_H_IDLE;
        endcase
        if (wr && addr == sfds_pkg::REG_CMD && r.st != sfds_pkg::SFDS_H_IDLE)
        begin
            evt[sfds_pkg::EVT_REFUSED] = 1'b1;
        end
        // write one clears, a same-cycle event wins
        if (wr && addr == sfds_pkg::REG_STATUS)
        begin
            n.status = r.status & ~wdata[1:0];
        end
        n.status = n.status | evt;
        if (wr && addr == sfds_pkg::REG_MASK)
        begin
            n.mask = wdata[1:0];
        end
        n.rdata = 16'h0000;
        if (rd)
        begin
            unique case (addr)
                sfds_pkg::REG_CMD:    n.rdata = r.cmd;
                sfds_pkg::REG_RX:     n.rdata = r.rx;
                sfds_pkg::REG_STATUS: n.rdata = {7'h00,
                                          r.st != sfds_pkg::SFDS_H_IDLE,
                                          6'h00, r.status};
                sfds_pkg::REG_MASK:   n.rdata = {14'h0000, r.mask};
                default:              n.rdata = 16'h0000;
            endcase
        end
        n.irq = |(n.status & n.mask);
    end

    // state register
    always_ff @(posedge ref_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            r        <= '0;
            r.cs_n   <= 1'b1;
            r.status <= sfds_pkg::EVT_RST;
        end
        else
        begin
            r <= n;
        end
    end

endmodule : sfds_host

// >>> rtl/sfds_device.sv
// device end: spi frame decode, summary flags and status return
`timescale 1ns/1ps
module sfds_device #(
    parameter int N_SPI   = sfds_pkg::N_SPI_SRC,   // spi error sources
    parameter int N_WAKE  = sfds_pkg::N_WAKE_SRC,  // wake sources
    parameter int N_CAN   = sfds_pkg::N_CAN_SRC,   // can sources
    parameter int N_LIN   = sfds_pkg::N_LIN_SRC,   // lin sources
    parameter int N_IO    = sfds_pkg::N_IO_SRC,    // io transitions
    parameter int N_PRE   = sfds_pkg::N_PRE_SRC,   // pre-regulator
    parameter int N_CORE  = sfds_pkg::N_CORE_SRC,  // core regulator
    parameter int N_OTHER = sfds_pkg::N_OTHER_SRC  // other regulators
) (
    input  wire logic               ref_clk,    // system clock
    input  wire logic               rstn,       // power-on reset, low
    sfds_link_if.dev                link,       // spi pins
    input  wire logic [N_SPI-1:0]   spi_src,    // spi error flags
    input  wire logic [N_WAKE-1:0]  wake_src,   // wake flags
    input  wire logic [N_CAN-1:0]   can_src,    // can diag flags
    input  wire logic [N_LIN-1:0]   lin_src,    // lin diag flags
    input  wire logic [N_IO-1:0]    io_src,     // io transition flags
    input  wire logic [N_PRE-1:0]   pre_src,    // pre-regulator flags
    input  wire logic [N_CORE-1:0]  core_src,   // core regulator flags
    input  wire logic [N_OTHER-1:0] other_src,  // other regulator flags
    input  wire logic [7:0]         rd_data,    // addressed register
    input  wire logic [7:0]         ext_status, // extended status
    output logic                    hdr_valid,  // header decoded pulse
    output logic                    hdr_write,  // 1 write, 0 read
    output logic                    hdr_target, // 1 fail-safe space
    output logic [4:0]              hdr_addr,   // register address
    output logic                    cmd_valid,  // good frame pulse
    output logic [7:0]              cmd_data,   // write data
    output logic                    parity_err, // bad write parity pulse
    output logic                    count_err,  // bad clock count pulse
    output logic [7:0]              summary     // summary flags
);

    typedef struct packed {
        sfds_pkg::sfds_dev_st_t st;
        logic [2:0]  sclk_s;
        logic [2:0]  cs_s;
        logic [2:0]  mosi_s;
        logic        sclk_f;
        logic        cs_f;
        logic        mosi_f;
        logic [4:0]  cnt;
        logic [15:0] rx;
        logic [15:0] tx;
        logic        miso;
        logic        hdr_valid;
        logic        hdr_write;
        logic        hdr_target;
        logic [4:0]  hdr_addr;
        logic        cmd_valid;
        logic        parity_err;
        logic        count_err;
        logic [7:0]  summary;
    } sfds_dev_state_t;

    sfds_dev_state_t r;
    sfds_dev_state_t n;
    logic            sclk_rise;
    logic            sclk_fall;
    logic            cs_fall;
    logic            cs_rise;
    logic [6:0]      hdr_bits;
    logic [7:0]      low_byte;

    // glitch filter: a level counts once stages two and three agree
    function automatic logic sfds_filt(input logic [2:0] s,
                                       input logic       f);
        return (s[1] == s[2]) ? s[2] : f;
    endfunction : sfds_filt

    // outputs straight from the state register
    assign link.miso  = r.miso;
    assign hdr_valid  = r.hdr_valid;
    assign hdr_write  = r.hdr_write;
    assign hdr_target = r.hdr_target;
    assign hdr_addr   = r.hdr_addr;
    assign cmd_valid  = r.cmd_valid;
    assign cmd_data   = r.rx[sfds_pkg::DATA_MSB:0];
    assign parity_err = r.parity_err;
    assign count_err  = r.count_err;
    assign summary    = r.summary;

    // next state: synchronisers, edge finding, frame sequencing
    always_comb
    begin
        n = r;
        n.sclk_s = {r.sclk_s[1:0], link.sclk};
        n.cs_s   = {r.cs_s[1:0], link.cs_n};
        n.mosi_s = {r.mosi_s[1:0], link.mosi};
        n.sclk_f = sfds_filt(r.sclk_s, r.sclk_f);
        n.cs_f   = sfds_filt(r.cs_s, r.cs_f);
        n.mosi_f = sfds_filt(r.mosi_s, r.mosi_f);
        sclk_rise = n.sclk_f & ~r.sclk_f;
        sclk_fall = ~n.sclk_f & r.sclk_f;
        cs_fall   = ~n.cs_f & r.cs_f;
        cs_rise   = n.cs_f & ~r.cs_f;
        // first seven bits in: rw, target, address
        hdr_bits  = {r.rx[5:0], n.mosi_f};
        // low byte depends on the direction of this frame
        low_byte  = (r.hdr_write == sfds_pkg::RW_WRITE) ? ext_status
                                                        : rd_data;
        n.hdr_valid  = 1'b0;
        n.cmd_valid  = 1'b0;
        n.parity_err = 1'b0;
        n.count_err  = 1'b0;

        // summary flags follow the or of their sources; the sources are
        // held by their own diagnostic registers until read, so a flag
        // falls only when the last of its sources has been cleared
        n.summary[sfds_pkg::FLAG_SPI]   = |spi_src;
        n.summary[sfds_pkg::FLAG_WAKE]  = |wake_src;
        n.summary[sfds_pkg::FLAG_CAN]   = |can_src;
        n.summary[sfds_pkg::FLAG_LIN]   = |lin_src;
        n.summary[sfds_pkg::FLAG_IO]    = |io_src;
        n.summary[sfds_pkg::FLAG_PRE]   = |pre_src;
        n.summary[sfds_pkg::FLAG_CORE]  = |core_src;
        n.summary[sfds_pkg::FLAG_OTHER] = |other_src;

        unique case (r.st)
            sfds_pkg::SFDS_DEV_IDLE:
                if (cs_fall)
                begin
                    // flags are frozen at frame start so a byte is coherent
                    n.st   = sfds_pkg::SFDS_DEV_SHIFT;
                    n.cnt  = 5'h00;
                    n.tx   = {r.summary, 8'h00};
                    n.miso = r.summary[7];
                end
            sfds_pkg::SFDS_DEV_SHIFT:
                if (cs_rise)
                begin
                    n.st   = sfds_pkg::SFDS_DEV_IDLE;
                    n.miso = 1'b0;
                    if (r.cnt != sfds_pkg::CNT_FRAME)
                    begin
                        n.count_err = 1'b1;
                    end
                    else if (r.hdr_write == sfds_pkg::RW_WRITE &&
                             r.rx[sfds_pkg::BIT_PAR] !=
                             sfds_pkg::sfds_par_bit(r.rx))
                    begin
                        // a bad write is dropped, never acted on
                        n.parity_err = 1'b1;
                    end
                    else
                    begin
                        n.cmd_valid = 1'b1;
                    end
                end
                else if (sclk_rise)
                begin
                    n.rx = {r.rx[14:0], n.mosi_f};
                    if (r.cnt != sfds_pkg::CNT_MAX)
                    begin
                        n.cnt = r.cnt + 5'h01;
                    end
                    if (r.cnt == sfds_pkg::CNT_HDR)
                    begin
                        // decode early so read data can arrive in time
                        n.hdr_valid  = 1'b1;
                        n.hdr_write  = hdr_bits[6];
                        n.hdr_target = hdr_bits[5];
                        n.hdr_addr   = hdr_bits[4:0];
                    end
                end
                else if (sclk_fall)
                begin
                    if (r.cnt == sfds_pkg::CNT_LOW)
                    begin
                        n.tx   = {low_byte, 8'h00};
                        n.miso = low_byte[7];
                    end
                    else
                    begin
                        n.tx   = {r.tx[14:0], 1'b0};
                        n.miso = r.tx[14];
                    end
                end
        endcase
    end

    // state register; cs stages reset high so release is no frame start
    always_ff @(posedge ref_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            r         <= '0;
            r.cs_s    <= 3'h7;
            r.cs_f    <= 1'b1;
            r.summary <= sfds_pkg::SUMMARY_RST;
        end
        else
        begin
            r <= n;
        end
    end

endmodule : sfds_device

// >>> sim/sfds_properties.sv
// link-level checks between the host end and the frame decoder
`timescale 1ns/1ps
module sfds_properties (
    input wire logic ref_clk, // system clock
    input wire logic rstn,    // async reset, low
    input wire logic sclk,    // serial clock
    input wire logic cs_n,    // frame select, low
    input wire logic mosi,    // host data
    input wire logic miso     // device data
);
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!rstn);

    logic        sclk_q; // sclk one cycle back
    logic [4:0]  n_rise; // rises seen in this frame
    logic [15:0] sh;     // mosi taken at each rise

    // rebuild the sent word; kept after cs_n rises for the checks
    always_ff @(posedge ref_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            sclk_q <= 1'b0;
            n_rise <= 5'h00;
            sh     <= 16'h0000;
        end
        else
        begin
            sclk_q <= sclk;
            if (cs_n)
                n_rise <= 5'h00;
            else if (sclk && !sclk_q)
            begin
                n_rise <= n_rise + 5'h01;
                sh     <= {sh[14:0], mosi};
            end
        end
    end

    property p_idle_clk; cs_n |-> !sclk; endproperty
    property p_lead; $fell(cs_n) |=> !sclk [*3]; endproperty
    property p_half; $rose(sclk) |=> sclk [*3]; endproperty
    property p_gap; $rose(cs_n) |=> cs_n [*4]; endproperty
    property p_count; $rose(cs_n) |-> n_rise == 5'h10; endproperty
    property p_mosi_hold; sclk && sclk_q |-> $stable(mosi); endproperty
    property p_miso_hold; sclk && sclk_q |-> $stable(miso); endproperty
    property p_miso_idle; cs_n [*6] |-> !miso; endproperty
    property p_write_par;
        $rose(cs_n) && sh[15] |-> sh[8] == ~^{sh[15:9], sh[7:0]};
    endproperty
    property p_read_zero; $rose(cs_n) && !sh[15] |-> sh[8:0] == 9'h000;
    endproperty

    a_idle_clk: assert property (p_idle_clk)
        else $error("sclk high outside a frame");
    a_lead: assert property (p_lead)
        else $error("sclk rose too soon after select");
    a_half: assert property (p_half)
        else $error("sclk high phase too short");
    a_gap: assert property (p_gap)
        else $error("select gap too short");
    a_count: assert property (p_count)
        else $error("frame not sixteen clocks");
    a_mosi_hold: assert property (p_mosi_hold)
        else $error("mosi moved while sclk high");
    a_miso_hold: assert property (p_miso_hold)
        else $error("miso moved while sclk high");
    a_miso_idle: assert property (p_miso_idle)
        else $error("miso not low when idle");
    a_write_par: assert property (p_write_par)
        else $error("write frame parity wrong");
    a_read_zero: assert property (p_read_zero)
        else $error("read frame parity or data not zero");

    c_write: cover property ($rose(cs_n) && sh[15]);
    c_read: cover property ($rose(cs_n) && !sh[15]);
    c_start: cover property ($fell(cs_n));
endmodule : sfds_properties

// >>> sim/sfds_tb_top.sv
// register-level bench: host end driving the decoder over the link
`timescale 1ns/1ps
`define CHK(nm, e, g) begin cmp_count++; if ((g) !== (e)) begin \
    n_mismatch++; $display("BAD %s exp %h got %h", nm, e, g); end end
module sfds_tb_top;
    logic        ref_clk = 1'b0;
    logic        rstn = 1'b0;
    logic [3:0]  addr = 4'h0;
    logic [15:0] wdata = 16'h0000;
    logic        wr = 1'b0;
    logic        rd = 1'b0;
    logic [15:0] rdata;
    logic        irq;
    logic [62:0] src = 63'h0;
    logic [7:0]  rd_data = 8'h00;
    logic [7:0]  ext_status = 8'hc3;
    logic        hdr_valid, hdr_write, hdr_target, cmd_valid;
    logic        parity_err, count_err;
    logic [4:0]  hdr_addr;
    logic [7:0]  cmd_data, summary;
    int          n_mismatch = 0, cmp_count = 0, cv_n = 0, err_n = 0;
    int          hv_n = 0;
    int          cyc = 0;
    int          lo[8] = '{55, 48, 39, 35, 29, 20, 15, 0};

    always #50 ref_clk = ~ref_clk;

    sfds_link_if lnk ();
    sfds_host #(.HALF_CYC(4)) sfds_host_i (.ref_clk(ref_clk), .rstn(rstn),
        .link(lnk), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
        .rdata(rdata), .irq(irq));
    sfds_device sfds_device_i (.ref_clk(ref_clk), .rstn(rstn), .link(lnk),
        .spi_src(src[62:55]), .wake_src(src[54:48]), .can_src(src[47:39]),
        .lin_src(src[38:35]), .io_src(src[34:29]), .pre_src(src[28:20]),
        .core_src(src[19:15]), .other_src(src[14:0]), .rd_data(rd_data),
        .ext_status(ext_status), .hdr_valid(hdr_valid),
        .hdr_write(hdr_write), .hdr_target(hdr_target),
        .hdr_addr(hdr_addr), .cmd_valid(cmd_valid), .cmd_data(cmd_data),
        .parity_err(parity_err), .count_err(count_err), .summary(summary));
    sfds_properties sfds_properties_i (.ref_clk(ref_clk), .rstn(rstn),
        .sclk(lnk.sclk), .cs_n(lnk.cs_n), .mosi(lnk.mosi),
        .miso(lnk.miso));

    task automatic test_done();
        $display("compares %0d mismatches %0d", cmp_count, n_mismatch);
        if (n_mismatch == 0 && cmp_count > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : test_done

    // pulse counters and hang guard; a frame takes about 150 cycles
    always @(posedge ref_clk)
    begin
        cyc++;
        if (cmd_valid === 1'b1) cv_n++;
        if (hdr_valid === 1'b1) hv_n++;
        if (parity_err === 1'b1 || count_err === 1'b1) err_n++;
        if (cyc == 20000)
        begin
            n_mismatch++;
            test_done();
        end
    end

    task automatic wr_reg(input logic [3:0] a, input logic [15:0] d);
        @(posedge ref_clk);
        wr <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge ref_clk);
        wr <= 1'b0;
    endtask : wr_reg

    // read data stand only in the cycle after the strobe
    task automatic rd_reg(input logic [3:0] a, output logic [15:0] d);
        @(posedge ref_clk);
        rd <= 1'b1;
        addr <= a;
        @(posedge ref_clk);
        rd <= 1'b0;
        #1 d = rdata;
    endtask : rd_reg

    // one frame end to end; dup retries the start while busy
    task automatic run_frame(input logic [15:0] f, input logic [7:0] sum,
                             input logic dup, input logic irq_on);
        int          c0;
        int          i;
        logic [15:0] d;
        c0 = cv_n;
        wr_reg(sfds_pkg::REG_CMD, f);
        if (dup)
        begin
            wr_reg(sfds_pkg::REG_CMD, ~f);
            rd_reg(sfds_pkg::REG_STATUS, d);
            `CHK("refused", 1'b1, d[1])
        end
        for (i = 0; i < 400; i++)
        begin
            rd_reg(sfds_pkg::REG_STATUS, d);
            if (d[0] === 1'b1 && d[8] === 1'b0) break;
        end
        for (i = 0; i < 20 && cv_n == c0; i++) @(posedge ref_clk);
        `CHK("accepted", c0 + 1, cv_n)
        `CHK("irq", irq_on, irq)
        rd_reg(sfds_pkg::REG_RX, d);
        `CHK("rx_high", sum, d[15:8])
        `CHK("rx_low", f[15] ? ext_status : rd_data, d[7:0])
        `CHK("hdr_write", f[15], hdr_write)
        `CHK("hdr_target", f[14], hdr_target)
        `CHK("hdr_addr", f[13:9], hdr_addr)
        `CHK("cmd_data", f[15] ? f[7:0] : 8'h00, cmd_data)
        wr_reg(sfds_pkg::REG_STATUS, 16'h0003);
        rd_reg(sfds_pkg::REG_STATUS, d);
        `CHK("cleared", 2'h0, d[1:0])
        `CHK("irq_low", 1'b0, irq)
    endtask : run_frame

    // one source per group in turn, all four rw/target pairs
    initial
    begin
        logic [15:0] f;
        logic [62:0] s;
        repeat (10) @(posedge ref_clk);
        rstn <= 1'b1;
        @(posedge ref_clk);
        #1 `CHK("summary_rst", 8'h00, summary)
        wr_reg(sfds_pkg::REG_MASK, 16'h0003);
        for (int g = 0; g < 8; g++)
        begin
            s = 63'h0;
            s[g[0] ? (g == 0 ? 62 : lo[g - 1] - 1) : lo[g]] = 1'b1;
            f = {g[1], g[0], 5'(g * 3 + 1), 1'b1, 8'h5a ^ 8'(g)};
            @(posedge ref_clk);
            src <= s;
            rd_data <= 8'h30 + 8'(g);
            repeat (2) @(posedge ref_clk);
            #1 `CHK("summary", 8'h80 >> g, summary)
            run_frame(f, 8'h80 >> g, g == 7, 1'b1);
        end
        wr_reg(sfds_pkg::REG_MASK, 16'h0000);
        src <= {63{1'b1}};
        run_frame(16'h7e00, 8'hff, 1'b0, 1'b0);
        @(posedge ref_clk);
        src <= 63'h0;
        repeat (2) @(posedge ref_clk);
        #1 `CHK("summary_clr", 8'h00, summary)
        `CHK("frame_errors", 0, err_n)
        `CHK("hdr_pulses", 9, hv_n)
        `CHK("frames", 9, cv_n)
        test_done();
    end
endmodule : sfds_tb_top
